// File: nvm_params.svh
// constants for the nvm access controller: offsets, fields, timing
// assumes a 50 MHz core clock and a calibrated oscillator enable
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define NVM_IO_OFS       6'h20
`define NVM_CTRL_ADDR    6'h1c
`define NVM_DATA_ADDR    6'h1d
`define NVM_ADRL_ADDR    6'h1e
`define NVM_ADRH_ADDR    6'h1f
// ----------------------------------------
// control fields
// ----------------------------------------
`define NVM_PM_HI        5
`define NVM_PM_LO        4
`define NVM_RIE          3
`define NVM_MPE          2
`define NVM_PE           1
`define NVM_RE           0
`define NVM_MODE_RST     2'h0
`define NVM_DATA_RST     8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define NVM_MPE_CYC      3'h4
`define NVM_WR_STALL     3'h2
`define NVM_RD_STALL     3'h4
`define NVM_OSC_KHZ      8000
`define NVM_ATOMIC_US    3400
`define NVM_SPLIT_US     1800
`endif

// File: nvm_pkg.sv
// types shared by the nvm access controller
// assumes nvm_params.svh is compiled alongside
package nvm_pkg;
  typedef enum logic [1:0] {
    NVM_IDLE = 2'b00,
    NVM_BUSY = 2'b01
  } nvm_state_t;
  // one core access to the i/o space
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_space;
    logic [6:0] addr;
    logic [7:0] wdata;
  } nvm_io_req_t;
endpackage : nvm_pkg

// File: nvm_ctrl.sv
// nvm access controller: byte eeprom behind four core i/o registers
// assumes one core access per cycle, an oscillator tick enable and an
// external array macro answering reads combinationally
//
// Overview of operation
// - master program enable self-clears four cycles after being set
// - program enable start only while master enable still set
// - mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// - program enable reads one while busy, cleared when time elapses
// - starting programming stalls the core two cycles
// - mode field writes ignored while program enable set
// - reset clears mode field to 00 unless programming in progress
// - reset during programming lets the write finish
// - read strobe loads addressed byte into data register at once
// - read strobe stalls the core four cycles
// - no reads and no address changes while programming
// - ready interrupt level when enabled, global flag set, not busy
// - data register feeds writes and receives read bytes
// - nine-bit linear address, reset value undefined
// - reserved bits read zero and ignore writes
// - registers at i/o address and at i/o address plus 0x20
// - programming time counted on the calibrated oscillator
// - write-only on unerased byte may store corrupted data
`include "nvm_params.svh"
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int unsigned ATOMIC_TICKS = `NVM_OSC_KHZ*`NVM_ATOMIC_US/1000,
  parameter int unsigned SPLIT_TICKS  = `NVM_OSC_KHZ*`NVM_SPLIT_US/1000
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire nvm_io_req_t io_req,
  input  wire logic        global_irq_en,
  input  wire logic        osc_tick,
  input  wire logic [7:0]  array_rdata,
  output logic      [7:0]  io_rdata,
  output logic             core_stall,
  output logic             ready_irq,
  output logic      [8:0]  array_addr,
  output logic      [7:0]  array_wdata,
  output logic             array_erase,
  output logic             array_write
);
  import nvm_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input nvm_io_req_t r, input logic [5:0] a);
    logic [6:0] eff;
    eff = r.data_space ? (r.addr - {1'b0, `NVM_IO_OFS}) : r.addr;
    return eff == {1'b0, a};
  endfunction : hit

  logic       wr_ctrl, wr_data, wr_adrl, wr_adrh;
  logic       rd_hit_c, rd_hit_d, rd_hit_l, rd_hit_h;
  assign wr_ctrl  = io_req.wr && hit(io_req, `NVM_CTRL_ADDR);
  assign wr_data  = io_req.wr && hit(io_req, `NVM_DATA_ADDR);
  assign wr_adrl  = io_req.wr && hit(io_req, `NVM_ADRL_ADDR);
  assign wr_adrh  = io_req.wr && hit(io_req, `NVM_ADRH_ADDR);
  assign rd_hit_c = io_req.rd && hit(io_req, `NVM_CTRL_ADDR);
  assign rd_hit_d = io_req.rd && hit(io_req, `NVM_DATA_ADDR);
  assign rd_hit_l = io_req.rd && hit(io_req, `NVM_ADRL_ADDR);
  assign rd_hit_h = io_req.rd && hit(io_req, `NVM_ADRH_ADDR);

  // ----------------------------------------
  // state
  // ----------------------------------------
  nvm_state_t  state_q, state_d;
  logic [1:0]  mode_q, mode_d;
  logic        rie_q, rie_d;
  logic        mpe_q, mpe_d;
  logic [2:0]  mpe_cnt_q, mpe_cnt_d;
  logic [8:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic [2:0]  stall_q, stall_d;
  logic [31:0] tick_q, tick_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic        erase_q, erase_d, write_q, write_d;
  logic        busy;
  logic        pe_start;
  logic [7:0]  ctrl_rd;

  assign busy = (state_q == NVM_BUSY);
  // start only with master enable armed
  assign pe_start = wr_ctrl && io_req.wdata[`NVM_PE] && mpe_q && !busy
                    && mode_q != 2'h3;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`NVM_PM_HI:`NVM_PM_LO] = mode_q;
    ctrl_rd[`NVM_RIE] = rie_q;
    ctrl_rd[`NVM_MPE] = mpe_q;
    ctrl_rd[`NVM_PE]  = busy;
  end

  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    rie_d     = rie_q;
    mpe_d     = mpe_q;
    mpe_cnt_d = mpe_cnt_q;
    addr_d    = addr_q;
    data_d    = data_q;
    stall_d   = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
    tick_d    = tick_q;
    erase_d   = erase_q;
    write_d   = write_q;
    rdata_d   = 8'h00;
    if (mpe_q) begin
      mpe_cnt_d = mpe_cnt_q - 3'h1;
      if (mpe_cnt_q == 3'h1) mpe_d = 1'b0;
    end
    if (wr_ctrl) begin
      rie_d = io_req.wdata[`NVM_RIE];
      if (!busy) mode_d = io_req.wdata[`NVM_PM_HI:`NVM_PM_LO];
      if (io_req.wdata[`NVM_MPE]) begin
        mpe_d     = 1'b1;
        mpe_cnt_d = `NVM_MPE_CYC;
      end
      // read lands in data register now
      if (io_req.wdata[`NVM_RE] && !busy) begin
        data_d  = array_rdata;
        stall_d = `NVM_RD_STALL;
      end
    end
    if (wr_data) data_d = io_req.wdata;
    if (wr_adrl && !busy) addr_d[7:0] = io_req.wdata;
    if (wr_adrh && !busy) addr_d[8] = io_req.wdata[0];
    if (pe_start) begin
      state_d = NVM_BUSY;
      mpe_d   = 1'b0;
      stall_d = `NVM_WR_STALL;
      tick_d  = (mode_q == 2'h0) ? ATOMIC_TICKS : SPLIT_TICKS;
      erase_d = (mode_q != 2'h2);
      write_d = (mode_q != 2'h1);
    end
    if (busy && osc_tick) begin
      tick_d = tick_q - 32'd1;
      if (tick_q == 32'd1) begin
        state_d = NVM_IDLE;
        erase_d = 1'b0;
        write_d = 1'b0;
      end
    end
    if (rd_hit_c) rdata_d = ctrl_rd;
    if (rd_hit_d) rdata_d = data_q;
    if (rd_hit_l) rdata_d = addr_q[7:0];
    if (rd_hit_h) rdata_d = {7'h00, addr_q[8]};
    irq_d = rie_d && global_irq_en && (state_d == NVM_IDLE);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // mode cleared only when idle
      // busy tested first: an unknown state at power-up must reset
      if (busy) begin
        state_q <= state_d;
        mode_q  <= mode_q;
        erase_q <= erase_d;
        write_q <= write_d;
        tick_q  <= tick_d;
        // data feeds the running write, so it must hold
        data_q  <= data_q;
      end else begin
        state_q <= NVM_IDLE;
        mode_q  <= `NVM_MODE_RST;
        erase_q <= 1'b0;
        write_q <= 1'b0;
        tick_q  <= 32'd0;
        data_q  <= `NVM_DATA_RST;
      end
      rie_q     <= 1'b0;
      mpe_q     <= 1'b0;
      mpe_cnt_q <= 3'h0;
      stall_q   <= 3'h0;
      rdata_q   <= 8'h00;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      rie_q     <= rie_d;
      mpe_q     <= mpe_d;
      mpe_cnt_q <= mpe_cnt_d;
      data_q    <= data_d;
      stall_q   <= stall_d;
      tick_q    <= tick_d;
      erase_q   <= erase_d;
      write_q   <= write_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
    end
  end

  // address has no reset, only a defined load path
  always_ff @(posedge clock) begin
    addr_q <= addr_d;
  end

  // stall counter is a flop, so the output is registered
  assign io_rdata    = rdata_q;
  assign core_stall  = stall_q != 3'h0;
  assign ready_irq   = irq_q;
  assign array_addr  = addr_q;
  assign array_wdata = data_q;
  assign array_erase = erase_q;
  assign array_write = write_q;
endmodule : nvm_ctrl

// File: nvm_ctrl_checker.sv
// assertions on nvm_ctrl ports
// assumes one clock and a sync active-low reset
module nvm_ctrl_checker (
  input wire logic                 clock,
  input wire logic                 reset_n,
  input wire nvm_pkg::nvm_io_req_t io_req,
  input wire logic [7:0]           io_rdata,
  input wire logic                 core_stall,
  input wire logic                 ready_irq,
  input wire logic                 array_erase,
  input wire logic                 array_write
);
  import nvm_pkg::*;
  // ------
  // checks
  // ------
  logic       busy, wc, rc;
  logic [2:0] since_q, since_d;
  assign busy = array_erase | array_write;
  assign wc = io_req.wr & (io_req.addr == {io_req.data_space, 6'h1c});
  assign rc = io_req.rd & (io_req.addr == {io_req.data_space, 6'h1c});
  // cycles since master enable write, saturating
  always_comb begin
    since_d = (since_q == 3'h7) ? since_q : since_q + 3'h1;
    if (wc & io_req.wdata[2]) since_d = 3'h1;
  end
  always_ff @(posedge clock) since_q <= reset_n ? since_d : 3'h7;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_MPE_LIFE: assert property (rc & !busy |=> io_rdata[2] ==
    ($past(since_q) inside {[3'h1:3'h4]})) else $error("mpe life");
  AST_NO_ARM: assert property (wc & io_req.wdata[1] & !busy
    & since_q > 3'h4 |=> !busy) else $error("unarmed start");
  AST_PE_STALL: assert property ($rose(busy) |->
    core_stall[*2] ##1 !core_stall) else $error("write stall");
  AST_RD_STALL: assert property (wc & io_req.wdata[1:0] == 2'h1
    & !busy |=> core_stall[*4] ##1 !core_stall) else $error("rd stall");
  AST_PE_BUSY: assert property (rc & busy |=> io_rdata[1])
    else $error("busy bit");
  AST_MODE_KEEP: assert property (busy ##1 busy |->
    $stable({array_erase, array_write})) else $error("mode moved");
  AST_RSV: assert property (rc |=> io_rdata[7:6] == 2'h0)
    else $error("reserved bits");
  AST_IRQ_BUSY: assert property (busy |-> !ready_irq)
    else $error("irq while busy");
  AST_BUSY_END: assert property ($rose(busy) |-> ##[1:200] !busy)
    else $error("busy too long");
  cover property ($rose(busy));
  cover property (ready_irq);
  cover property (wc & io_req.wdata[0]);
endmodule : nvm_ctrl_checker
bind nvm_ctrl nvm_ctrl_checker chk (.clock(clock), .reset_n(reset_n),
  .io_req(io_req), .io_rdata(io_rdata), .core_stall(core_stall),
  .ready_irq(ready_irq), .array_erase(array_erase),
  .array_write(array_write));

// File: nvm_array_model.sv
// byte array model behind the nvm controller
// assumes address and data held through each operation
module nvm_array_model (
  input wire logic       clock,
  input wire logic [8:0] array_addr,
  input wire logic [7:0] array_wdata,
  input wire logic       array_erase,
  input wire logic       array_write,
  output logic     [7:0] array_rdata
);
  // -----
  // store
  // -----
  logic [7:0] mem [512];
  assign array_rdata = mem[array_addr];
  // erase sets ones, write only clears
  always_ff @(posedge clock) begin
    if (array_erase | array_write) begin
      mem[array_addr] <= (array_erase ? 8'hff : mem[array_addr])
        & (array_write ? array_wdata : 8'hff);
    end
  end
endmodule : nvm_array_model

// File: nvm_ctrl_tb_top.sv
// bench for nvm_ctrl with a byte array model
// assumes short tick counts, one core access at a time
module nvm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_pkg::*;
  // -----
  // bench
  // -----
  logic        clock, reset_n, gie, osc_tick, core_stall, ready_irq, ae, aw;
  logic [7:0]  ard, io_rdata, awd, v;
  logic [8:0]  aa;
  logic [1:0]  ew;
  nvm_io_req_t io_req;
  int          err_total, num_checks, cyc;
  nvm_ctrl #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) dut (.clock, .reset_n,
    .io_req, .global_irq_en(gie), .osc_tick, .array_rdata(ard), .io_rdata,
    .core_stall, .ready_irq, .array_addr(aa), .array_wdata(awd),
    .array_erase(ae), .array_write(aw));
  nvm_array_model far (.clock, .array_addr(aa), .array_wdata(awd),
    .array_erase(ae), .array_write(aw), .array_rdata(ard));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // tick every 4th cycle; ceiling cuts a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    osc_tick <= cyc[1:0] == 2'h0;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // one access; waits out any stall it causes
  task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
    io_req <= '{w, !w, a[5], a, d};
    @(posedge clock);
    io_req <= '0;
    #1;
    v = io_rdata;
    ew = {ae, aw};
    while (core_stall) @(negedge clock);
    @(posedge clock);
  endtask : acc
  task automatic rd(logic [6:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), v, e);
  endtask : rd
  task automatic prog(logic [7:0] c);
    acc(1'b1, 7'h1c, c);
    acc(1'b1, 7'h1c, c | 8'h04);
    acc(1'b1, 7'h3c, c | 8'h02);
  endtask : prog
  task automatic idle();
    repeat (40) begin
      acc(1'b0, 7'h1c, 8'h00);
      if (v[1] === 1'b0) break;
    end
  endtask : idle
  task automatic rst(int n);
    reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
  endtask : rst
  task automatic t_atomic();
    rd(7'h3d, 8'h00);
    acc(1'b1, 7'h1f, 8'hff);
    rd(7'h3f, 8'h01);
    acc(1'b1, 7'h3e, 8'h23);
    acc(1'b1, 7'h1d, 8'h5a);
    prog(8'hc0);
    rd(7'h1c, 8'h02);
    acc(1'b1, 7'h1e, 8'h00);
    acc(1'b1, 7'h1c, 8'h10);
    idle();
    rd(7'h1c, 8'h00);
    acc(1'b1, 7'h1c, 8'h01);
    rd(7'h1d, 8'h5a);
  endtask : t_atomic
  task automatic t_modes();
    logic [7:0] e [4] = '{8'h00, 8'hff, 8'h0f, 8'h0f};
    for (int m = 1; m < 4; m++) begin
      acc(1'b1, 7'h1d, 8'h0f);
      prog(8'(m << 4));
      chk("mode", {6'h00, ew}, m == 3 ? 8'h00 : {6'h00, m[0], m[1]});
      idle();
      acc(1'b1, 7'h1c, 8'h01);
      rd(7'h1d, e[m]);
    end
  endtask : t_modes
  task automatic t_arm();
    acc(1'b1, 7'h1c, 8'h04);
    rd(7'h1c, 8'h04);
    repeat (3) @(posedge clock);
    rd(7'h1c, 8'h00);
    acc(1'b1, 7'h1c, 8'h02);
    rd(7'h1c, 8'h00);
  endtask : t_arm
  task automatic t_irq();
    gie <= 1'b1;
    acc(1'b1, 7'h1c, 8'h08);
    @(negedge clock);
    chk("irq_on", {7'h00, ready_irq}, 8'h01);
    @(posedge clock);
    gie <= 1'b0;
    repeat (2) @(negedge clock);
    chk("irq_off", {7'h00, ready_irq}, 8'h00);
    @(posedge clock);
  endtask : t_irq
  task automatic t_rst();
    prog(8'h20);
    rst(1);
    rd(7'h1c, 8'h22);
    idle();
    acc(1'b1, 7'h1c, 8'h10);
    rst(1);
    rd(7'h1c, 8'h00);
  endtask : t_rst
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    gie = 1'b0;
    osc_tick = 1'b0;
    io_req = '0;
    rst(10);
    t_atomic();
    t_modes();
    t_arm();
    t_irq();
    t_rst();
    end_of_test();
  end
endmodule : nvm_ctrl_tb_top
